//--- dv/universal_serial_shift_unit_tb_top.sv
// Bench for the shift unit facing its partner over the link
`timescale 1ns/100ps
`default_nettype none
module universal_serial_shift_unit_tb_top;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [1:0] addr = 2'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata;
   logic wake;
   logic go = 1'b0;
   logic [1:0] op = 2'h0;
   logic two = 1'b0;
   logic [7:0] tx = 8'h00;
   logic [7:0] rx;
   logic ack_bit;
   logic done;
   logic held;
   logic [7:0] d;
   int num_errors = 0;
   int compares = 0;
   // ****************
   // Design and checker
   // ****************
   usi_link_if i_usi_link_if ();
   usi_device i_usi_device (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .wake(wake), .link(i_usi_link_if.device));
   usi_peer #(.HALF_CYC(8)) i_usi_peer (.mclk(mclk), .rst_n(rst_n), .go(go), .op(op),
      .two_wire(two), .tx(tx), .rx(rx), .ack_bit(ack_bit), .busy(), .done(done),
      .link(i_usi_link_if.peer));
   usi_checker i_usi_checker (.mclk(mclk), .rst_n(rst_n),
      .dev_clk_o(i_usi_link_if.dev_clk_o), .dev_clk_oe(i_usi_link_if.dev_clk_oe),
      .dev_dat_o(i_usi_link_if.dev_dat_o), .dev_dat_oe(i_usi_link_if.dev_dat_oe),
      .peer_clk_o(i_usi_link_if.peer_clk_o), .peer_clk_oe(i_usi_link_if.peer_clk_oe),
      .peer_do(i_usi_link_if.peer_do), .sclk_line(i_usi_link_if.sclk_line),
      .dat_line(i_usi_link_if.dat_line));
   // Device holding the clock line down
   assign held = i_usi_link_if.dev_clk_oe & ~i_usi_link_if.dev_clk_o;
   // 200 MHz system clock
   always #2.5 mclk = ~mclk;
   // ****************
   // Tasks
   // ****************
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [1:0] a, input logic [7:0] v);
      @(posedge mclk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rreg(input logic [1:0] a);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic rchk(input logic [1:0] a, input logic [7:0] exp, input logic [7:0] m);
      rreg(a);
      chk(d & m, exp);
   endtask
   task automatic pgo(input logic [1:0] o, input logic w, input logic [7:0] t);
      @(posedge mclk);
      op <= o;
      two <= w;
      tx <= t;
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
   endtask
   // Bounded wait; a partner stuck on a held clock ends here
   task automatic pwait;
      int n;
      n = 0;
      while (done !== 1'b1 && n < 5000)
      begin
         @(posedge mclk);
         #1 n++;
      end
      if (n == 5000) num_errors++;
   endtask
   task automatic final_report;
      $display("Compares %0d, errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ****************
   // Tests
   // ****************
   initial
   begin
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (2) @(posedge mclk);
      // Reset values
      rchk(usi_pkg::ADDR_STATUS, 8'h00, 8'hFF);
      rchk(usi_pkg::ADDR_PORT, 8'h03, 8'h0F);
      rchk(usi_pkg::ADDR_CTRL, 8'h00, 8'hFF);
      // Software clocking: counter preset 8, eight shifts wrap it
      wreg(usi_pkg::ADDR_DATA, 8'hA5);
      wreg(usi_pkg::ADDR_STATUS, 8'h48);
      for (int i = 0; i < 16; i++)
         wreg(usi_pkg::ADDR_CTRL, {4'h5, 2'h0, i[0], 1'b1});
      rchk(usi_pkg::ADDR_DATA, 8'h00, 8'hFF);
      rchk(usi_pkg::ADDR_STATUS, 8'h40, 8'hEF);
      rchk(usi_pkg::ADDR_PORT, 8'h03, 8'h0F);
      chk({7'h00, wake}, 8'h01);
      wreg(usi_pkg::ADDR_STATUS, 8'h40);
      wreg(usi_pkg::ADDR_CTRL, 8'h51);
      rchk(usi_pkg::ADDR_PORT, 8'h02, 8'h0F);
      rchk(usi_pkg::ADDR_STATUS, 8'h00, 8'hEF);
      chk({7'h00, wake}, 8'h00);
      // Three-wire byte exchange on the external clock
      wreg(usi_pkg::ADDR_PORT, 8'h0B);
      wreg(usi_pkg::ADDR_CTRL, 8'h18);
      wreg(usi_pkg::ADDR_DATA, 8'h3C);
      pgo(usi_pkg::OP_BYTE, 1'b0, 8'hC9);
      pwait();
      chk(rx, 8'h3C);
      rchk(usi_pkg::ADDR_DATA, 8'hC9, 8'hFF);
      rchk(usi_pkg::ADDR_STATUS, 8'h40, 8'h4F);
      // Start outside two-wire mode is ignored
      wreg(usi_pkg::ADDR_CTRL, 8'h10);
      wreg(usi_pkg::ADDR_STATUS, 8'hE0);
      pgo(usi_pkg::OP_START, 1'b1, 8'h00);
      pwait();
      rchk(usi_pkg::ADDR_STATUS, 8'h00, 8'h80);
      // Two-wire slave: start, address byte, acknowledge
      wreg(usi_pkg::ADDR_PORT, 8'h0F);
      wreg(usi_pkg::ADDR_DATA, 8'hFF);
      wreg(usi_pkg::ADDR_CTRL, 8'hA8);
      wreg(usi_pkg::ADDR_STATUS, 8'hE0);
      pgo(usi_pkg::OP_START, 1'b1, 8'h00);
      pwait();
      rchk(usi_pkg::ADDR_STATUS, 8'h80, 8'hE0);
      chk({7'h00, wake}, 8'h01);
      chk({7'h00, held}, 8'h01);
      wreg(usi_pkg::ADDR_STATUS, 8'h80);
      pgo(usi_pkg::OP_BYTE, 1'b1, 8'hA6);
      d = 8'h00;
      repeat (300)
         if (d[6] !== 1'b1) rreg(usi_pkg::ADDR_STATUS);
      chk(d & 8'hEF, 8'h40);
      chk({7'h00, held}, 8'h01);
      rchk(usi_pkg::ADDR_DATA, 8'hA6, 8'hFF);
      wreg(usi_pkg::ADDR_DATA, 8'h00);
      wreg(usi_pkg::ADDR_STATUS, 8'h4E);
      pwait();
      chk({7'h00, ack_bit}, 8'h00);
      rchk(usi_pkg::ADDR_STATUS, 8'h40, 8'hEF);
      chk({7'h00, held}, 8'h01);
      // Release data and clock hold, then a stop from the partner
      wreg(usi_pkg::ADDR_DATA, 8'hFF);
      wreg(usi_pkg::ADDR_STATUS, 8'h40);
      rchk(usi_pkg::ADDR_STATUS, 8'h00, 8'hE0);
      chk({7'h00, held}, 8'h00);
      pgo(usi_pkg::OP_STOP, 1'b1, 8'h00);
      pwait();
      rchk(usi_pkg::ADDR_STATUS, 8'h20, 8'hE0);
      final_report();
   end
   // Watchdog: tests need a few hundred cycles, allow twenty thousand
   initial
   begin
      #100000;
      num_errors++;
      final_report();
   end
endmodule
`default_nettype wire

//--- dv/usi_checker.sv
// Link checker for the shift unit and its partner
`timescale 1ns/100ps
`default_nettype none
module usi_checker (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic dev_clk_o,
   input wire logic dev_clk_oe,
   input wire logic dev_dat_o,
   input wire logic dev_dat_oe,
   input wire logic peer_clk_o,
   input wire logic peer_clk_oe,
   input wire logic peer_do,
   input wire logic sclk_line,
   input wire logic dat_line
);
   // ****************
   // Helpers
   // ****************
   logic hold;
   logic rel;
   // Device pulling the clock down, partner letting it go
   assign hold = dev_clk_oe & ~dev_clk_o;
   assign rel = ~peer_clk_oe | peer_clk_o;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   // Start from an open-drain partner; a device pushing data high is not two-wire
   sequence start_seq;
      $fell(dat_line) && sclk_line && !peer_clk_oe && !(dev_dat_oe && dev_dat_o);
   endsequence
   sequence held_seq;
      ##[1:8] hold;
   endsequence
   // ****************
   // Assertions
   // ****************
   clk_high_min_a: assert property ($rose(sclk_line) |-> sclk_line [*2])
      else $error("clock high phase too short");
   clk_low_min_a: assert property ($fell(sclk_line) |-> !sclk_line [*2])
      else $error("clock low phase too short");
   do_hold_high_a: assert property (sclk_line && $past(sclk_line) && dev_dat_oe
      |-> $stable(dev_dat_o)) else $error("data out moved while clock high");
   start_hold_a: assert property (start_seq ##[1:20] $fell(sclk_line) |-> held_seq)
      else $error("no clock hold after start");
   hold_low_a: assert property ($rose(hold) |-> !sclk_line)
      else $error("clock hold began while clock high");
   stretch_kept_a: assert property (hold && $past(hold) && $past(rel) |-> rel)
      else $error("partner drove clock during hold");
   setup_half_a: assert property ($rose(sclk_line) |-> peer_do == $past(peer_do, 4))
      else $error("partner data not set up before rise");
   peer_do_low_a: assert property ($changed(peer_do) |-> !sclk_line)
      else $error("partner data moved while clock high");
endmodule
`default_nettype wire

//--- logic/usi_device.sv
// Universal serial shift unit: three-wire and two-wire shift engine
`timescale 1ns/100ps
`default_nettype none
module usi_device (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   output logic wake,
   usi_link_if.device link
);
   // ****************************************************
   // Decoding
   // ****************************************************
   function automatic logic hit(input logic stb, input logic [1:0] a, input logic [1:0] t);
      hit = stb & (a == t);
   endfunction

   // ****************************************************
   // Pin synchronisers
   // ****************************************************
   logic [2:0] sync1_reg, sync2_reg, sync1_next, sync2_next;
   logic [1:0] prev_reg, prev_next;

   // Clock, data and data-in lines pass two flops before use
   always_comb
   begin
      sync1_next = {link.di_line, link.dat_line, link.sclk_line};
      sync2_next = sync1_reg;
      prev_next = sync2_reg[1:0];
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         sync1_reg <= 3'h7;
         sync2_reg <= 3'h7;
         prev_reg <= 2'h3;
      end
      else
      begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
         prev_reg <= prev_next;
      end
   end

   // ****************************************************
   // Shift engine, flags and registers
   // ****************************************************
   logic [7:0] shreg_reg, shreg_next, rdata_reg, rdata_next;
   logic [3:0] cnt_reg, cnt_next, port_reg, port_next;
   logic [5:0] ctrl_reg, ctrl_next;
   logic sflag_reg, sflag_next, oflag_reg, oflag_next, pflag_reg, pflag_next;
   logic latch_reg, latch_next, lopen_reg, lopen_next;
   logic armed_reg, armed_next, shold_reg, shold_next;
   logic clk_o_reg, clk_o_next, clk_oe_reg, clk_oe_next;
   logic dat_o_reg, dat_o_next, dat_oe_reg, dat_oe_next, wake_reg, wake_next;
   logic scl_s, sda_s, di_s, scl_p, sda_p, rise, fall;
   logic two, three, ext, wr_ctrl, wr_stat, tc, sc;
   logic sample_edge, out_edge, tick, di_bit, coll;
   logic [1:0] wm;

   // Control field positions, shifted down past the two strobe bits
   localparam int CTRL_WM_HI = usi_pkg::CTRL_WM_HI;
   localparam int CTRL_WM_LO = usi_pkg::CTRL_WM_LO;
   localparam int CTRL_EXT = usi_pkg::CTRL_EXT;
   localparam int CTRL_EDGE = usi_pkg::CTRL_EDGE;
   localparam int CTRL_WAKE_OVF = usi_pkg::CTRL_WAKE_OVF;
   localparam int CTRL_WAKE_START = usi_pkg::CTRL_WAKE_START;

   always_comb
   begin
      scl_s = sync2_reg[0];
      sda_s = sync2_reg[1];
      di_s = sync2_reg[2];
      scl_p = prev_reg[0];
      sda_p = prev_reg[1];
      // Edges seen only through the sampler, so clock must stay below mclk/4
      rise = scl_s & ~scl_p;
      fall = ~scl_s & scl_p;
      wm = ctrl_reg[CTRL_WM_HI-2:CTRL_WM_LO-2];
      two = (wm == usi_pkg::WM_TWO);
      three = (wm == usi_pkg::WM_THREE);
      ext = ctrl_reg[CTRL_EXT-2];
      wr_ctrl = hit(wr, addr, usi_pkg::ADDR_CTRL);
      wr_stat = hit(wr, addr, usi_pkg::ADDR_STATUS);
      tc = wr_ctrl & wdata[usi_pkg::CTRL_TOGGLE];
      sc = wr_ctrl & wdata[usi_pkg::CTRL_SHIFT];
      // Clock source: pin edges or the software shift strobe
      if (ext)
      begin
         sample_edge = ctrl_reg[CTRL_EDGE-2] ? fall : rise;
         out_edge = ctrl_reg[CTRL_EDGE-2] ? rise : fall;
         tick = rise | fall;
      end
      else
      begin
         sample_edge = sc;
         out_edge = 1'b0;
         tick = sc;
      end
      // Two-wire takes data from the shared data line, three-wire from data-in
      di_bit = two ? sda_s : di_s;
      // A data write in the same cycle wins over a shift
      shreg_next = shreg_reg;
      if (hit(wr, addr, usi_pkg::ADDR_DATA))
         shreg_next = wdata;
      else if (sample_edge)
         shreg_next = {shreg_reg[6:0], di_bit};
      // Counter counts both pin edges on the external clock, the shift strobe otherwise
      cnt_next = wr_stat ? wdata[3:0] : (tick ? cnt_reg + 4'h1 : cnt_reg);
      oflag_next = oflag_reg & ~(wr_stat & wdata[usi_pkg::STAT_OVF]);
      if (tick && cnt_reg == usi_pkg::CNT_MAX && !wr_stat)
         oflag_next = 1'b1;
      // Latch closes at sampling, reopens at the opposite edge
      lopen_next = lopen_reg;
      if (ext && sample_edge)
         lopen_next = 1'b0;
      else if (ext && out_edge)
         lopen_next = 1'b1;
      latch_next = latch_reg;
      if (!ext || ((lopen_reg || out_edge) && !sample_edge))
         latch_next = shreg_next[7];
      // Start and stop detection on the bus in two-wire mode only
      sflag_next = sflag_reg & ~(wr_stat & wdata[usi_pkg::STAT_START]);
      armed_next = armed_reg;
      shold_next = shold_reg;
      if (!sflag_next)
      begin
         armed_next = 1'b0;
         shold_next = 1'b0;
      end
      if (armed_reg && fall)
      begin
         armed_next = 1'b0;
         shold_next = 1'b1;
      end
      if (two && scl_s && scl_p && sda_p && !sda_s)
      begin
         sflag_next = 1'b1;
         armed_next = 1'b1;
      end
      pflag_next = pflag_reg & ~(wr_stat & wdata[usi_pkg::STAT_STOP]);
      if (two && scl_s && scl_p && !sda_p && sda_s)
         pflag_next = 1'b1;
      coll = two & (shreg_reg[7] != sda_s);
      // Control keeps mode bits; strobes act once and read back zero
      ctrl_next = wr_ctrl ? wdata[7:2] : ctrl_reg;
      port_next = hit(wr, addr, usi_pkg::ADDR_PORT) ? wdata[3:0] : port_reg;
      if (tc)
         port_next[usi_pkg::PORT_CLK] = ~port_reg[usi_pkg::PORT_CLK];
      // Pin drivers: push-pull in three-wire, open-drain in two-wire
      clk_o_next = 1'b0;
      clk_oe_next = 1'b0;
      dat_o_next = 1'b0;
      dat_oe_next = 1'b0;
      if (three)
      begin
         clk_o_next = port_next[usi_pkg::PORT_CLK];
         clk_oe_next = port_next[usi_pkg::PORT_CLK_OE];
         dat_o_next = latch_next;
         dat_oe_next = port_next[usi_pkg::PORT_DAT_OE];
      end
      else if (two)
      begin
         // Hold clock low after start or overflow until the flag clears
         clk_oe_next = (port_next[usi_pkg::PORT_CLK_OE] & ~port_next[usi_pkg::PORT_CLK])
            | shold_next | oflag_next;
         dat_oe_next = port_next[usi_pkg::PORT_DAT_OE]
            & ~(latch_next & port_next[usi_pkg::PORT_DAT]);
      end
      wake_next = (oflag_next & ctrl_next[CTRL_WAKE_OVF-2])
         | (sflag_next & ctrl_next[CTRL_WAKE_START-2]);
      // Read data valid for exactly one cycle after the strobe
      rdata_next = 8'h00;
      if (rd)
      begin
         case (addr)
            usi_pkg::ADDR_DATA: rdata_next = shreg_reg;
            usi_pkg::ADDR_STATUS: rdata_next = {sflag_reg, oflag_reg, pflag_reg, coll, cnt_reg};
            usi_pkg::ADDR_CTRL: rdata_next = {ctrl_reg, 2'b00};
            usi_pkg::ADDR_PORT: rdata_next = {4'h0, port_reg};
            default: rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         shreg_reg <= usi_pkg::RESET_BYTE;
         cnt_reg <= 4'h0;
         oflag_reg <= 1'b0;
         sflag_reg <= 1'b0;
         pflag_reg <= 1'b0;
         armed_reg <= 1'b0;
         shold_reg <= 1'b0;
         latch_reg <= 1'b0;
         lopen_reg <= 1'b1;
         ctrl_reg <= 6'h00;
         port_reg <= usi_pkg::PORT_RESET;
         clk_o_reg <= 1'b0;
         clk_oe_reg <= 1'b0;
         dat_o_reg <= 1'b0;
         dat_oe_reg <= 1'b0;
         wake_reg <= 1'b0;
         rdata_reg <= 8'h00;
      end
      else
      begin
         shreg_reg <= shreg_next;
         cnt_reg <= cnt_next;
         oflag_reg <= oflag_next;
         sflag_reg <= sflag_next;
         pflag_reg <= pflag_next;
         armed_reg <= armed_next;
         shold_reg <= shold_next;
         latch_reg <= latch_next;
         lopen_reg <= lopen_next;
         ctrl_reg <= ctrl_next;
         port_reg <= port_next;
         clk_o_reg <= clk_o_next;
         clk_oe_reg <= clk_oe_next;
         dat_o_reg <= dat_o_next;
         dat_oe_reg <= dat_oe_next;
         wake_reg <= wake_next;
         rdata_reg <= rdata_next;
      end
   end

   // Outputs straight from flops
   assign rdata = rdata_reg;
   assign wake = wake_reg;
   assign link.dev_clk_o = clk_o_reg;
   assign link.dev_clk_oe = clk_oe_reg;
   assign link.dev_dat_o = dat_o_reg;
   assign link.dev_dat_oe = dat_oe_reg;
endmodule
`default_nettype wire

//--- logic/usi_peer.sv
// Link partner: hardware master that clocks bytes, starts and stops
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module usi_peer #(
   parameter int HALF_CYC = usi_pkg::SCLK_HALF_CYC
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic go,
   input wire logic [1:0] op,
   input wire logic two_wire,
   input wire logic [7:0] tx,
   output logic [7:0] rx,
   output logic ack_bit,
   output logic busy,
   output logic done,
   usi_link_if.peer link
);
   typedef enum {IDLE, SETUP, RISE_WAIT, HIGH, ST_HI, ST_LO, ST_END, SP_LO, SP_HI, SP_END,
      FIN} state_t;
   // Half period never shorter than the device can sample
   localparam int HALF = (HALF_CYC < usi_pkg::SCLK_MIN_HALF_CYC) ?
      usi_pkg::SCLK_MIN_HALF_CYC : HALF_CYC;
   localparam logic [15:0] HALF_L = 16'(HALF - 1);

   logic [1:0] s1_reg, s2_reg, s1_next;
   state_t st_reg, st_next;
   logic [15:0] tim_reg, tim_next;
   logic [8:0] sh_reg, sh_next, rs_reg, rs_next;
   logic [3:0] bit_reg, bit_next;
   logic clk_reg, clk_next, sda_reg, sda_next, do_reg, do_next;
   logic two_reg, two_next, busy_reg, busy_next, done_reg, done_next;
   logic [7:0] rx_reg, rx_next;
   logic ack_reg, ack_next, scl_s, dat_s, tz;

   // ****************************************************
   // Master sequencer
   // ****************************************************
   always_comb
   begin
      s1_next = {link.dat_line, link.sclk_line};
      scl_s = s2_reg[0];
      dat_s = s2_reg[1];
      tz = (tim_reg == 16'h0000);
      st_next = st_reg;
      tim_next = tz ? tim_reg : tim_reg - 16'h0001;
      sh_next = sh_reg;
      rs_next = rs_reg;
      bit_next = bit_reg;
      clk_next = clk_reg;
      sda_next = sda_reg;
      do_next = do_reg;
      two_next = two_reg;
      busy_next = busy_reg;
      done_next = 1'b0;
      rx_next = rx_reg;
      ack_next = ack_reg;
      case (st_reg)
         IDLE:
         begin
            if (go)
            begin
               busy_next = 1'b1;
               two_next = two_wire;
               tim_next = HALF_L;
               case (op)
                  usi_pkg::OP_START:
                  begin
                     clk_next = 1'b1;
                     sda_next = 1'b1;
                     st_next = ST_HI;
                  end
                  usi_pkg::OP_STOP:
                  begin
                     clk_next = 1'b0;
                     sda_next = 1'b0;
                     st_next = SP_LO;
                  end
                  default:
                  begin
                     // Byte out first, then wait half a period before rising
                     sh_next = {tx, 1'b1};
                     bit_next = 4'h0;
                     clk_next = 1'b0;
                     sda_next = two_wire ? tx[7] : 1'b1;
                     do_next = tx[7];
                     st_next = SETUP;
                  end
               endcase
            end
         end
         SETUP:
         begin
            if (tz)
            begin
               clk_next = 1'b1;
               st_next = RISE_WAIT;
            end
         end
         RISE_WAIT:
         begin
            // Slave may stretch: count the high phase only once seen high
            if (scl_s)
            begin
               rs_next = {rs_reg[7:0], dat_s};
               tim_next = HALF_L;
               st_next = HIGH;
            end
         end
         HIGH:
         begin
            if (tz)
            begin
               // Data moves only together with the falling edge, in the same cycle
               clk_next = 1'b0;
               bit_next = bit_reg + 4'h1;
               sh_next = {sh_reg[7:0], 1'b1};
               sda_next = two_reg ? sh_reg[7] : 1'b1;
               do_next = sh_reg[7];
               tim_next = HALF_L;
               if (bit_reg == (two_reg ? 4'h8 : 4'h7))
                  st_next = FIN;
               else
                  st_next = SETUP;
            end
         end
         ST_HI:
         begin
            if (tz && scl_s && dat_s)
            begin
               sda_next = 1'b0;
               tim_next = HALF_L;
               st_next = ST_LO;
            end
         end
         ST_LO:
         begin
            if (tz)
            begin
               clk_next = 1'b0;
               tim_next = HALF_L;
               st_next = ST_END;
            end
         end
         SP_LO:
         begin
            if (tz)
            begin
               clk_next = 1'b1;
               st_next = SP_HI;
            end
         end
         SP_HI:
         begin
            if (scl_s)
            begin
               sda_next = 1'b1;
               tim_next = HALF_L;
               st_next = SP_END;
            end
         end
         ST_END, SP_END, FIN:
         begin
            if (tz)
            begin
               if (st_reg == FIN)
               begin
                  sda_next = 1'b1;
                  rx_next = two_reg ? rs_reg[8:1] : rs_reg[7:0];
                  ack_next = two_reg & rs_reg[0];
               end
               busy_next = 1'b0;
               done_next = 1'b1;
               st_next = IDLE;
            end
         end
         default: st_next = IDLE;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         s1_reg <= 2'h3;
         s2_reg <= 2'h3;
         st_reg <= IDLE;
         tim_reg <= 16'h0000;
         sh_reg <= 9'h1FF;
         rs_reg <= 9'h000;
         bit_reg <= 4'h0;
         clk_reg <= 1'b0;
         sda_reg <= 1'b1;
         do_reg <= 1'b0;
         two_reg <= 1'b0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
         rx_reg <= 8'h00;
         ack_reg <= 1'b0;
      end
      else
      begin
         s1_reg <= s1_next;
         s2_reg <= s1_reg;
         st_reg <= st_next;
         tim_reg <= tim_next;
         sh_reg <= sh_next;
         rs_reg <= rs_next;
         bit_reg <= bit_next;
         clk_reg <= clk_next;
         sda_reg <= sda_next;
         do_reg <= do_next;
         two_reg <= two_next;
         busy_reg <= busy_next;
         done_reg <= done_next;
         rx_reg <= rx_next;
         ack_reg <= ack_next;
      end
   end

   // Push-pull clock in three-wire, open-drain lines in two-wire
   assign link.peer_clk_o = two_reg ? 1'b0 : clk_reg;
   assign link.peer_clk_oe = two_reg ? ~clk_reg : 1'b1;
   assign link.peer_sda_o = 1'b0;
   assign link.peer_sda_oe = two_reg & ~sda_reg;
   assign link.peer_do = do_reg;
   assign rx = rx_reg;
   assign ack_bit = ack_reg;
   assign busy = busy_reg;
   assign done = done_reg;
endmodule
`default_nettype wire

//--- pkg/usi_link_if.sv
// Serial link between the shift unit and its partner, with wired-AND lines
`timescale 1ns/100ps
`default_nettype none
interface usi_link_if;
   logic dev_clk_o;
   logic dev_clk_oe;
   logic dev_dat_o;
   logic dev_dat_oe;
   logic peer_clk_o;
   logic peer_clk_oe;
   logic peer_sda_o;
   logic peer_sda_oe;
   logic peer_do;
   logic sclk_line;
   logic dat_line;
   logic di_line;
   // Pulled-up lines; any enabled low driver wins
   assign sclk_line = ~((dev_clk_oe & ~dev_clk_o) | (peer_clk_oe & ~peer_clk_o));
   assign dat_line = ~((dev_dat_oe & ~dev_dat_o) | (peer_sda_oe & ~peer_sda_o));
   assign di_line = peer_do;
   modport device (
      output dev_clk_o,
      output dev_clk_oe,
      output dev_dat_o,
      output dev_dat_oe,
      input sclk_line,
      input dat_line,
      input di_line
   );
   modport peer (
      output peer_clk_o,
      output peer_clk_oe,
      output peer_sda_o,
      output peer_sda_oe,
      output peer_do,
      input sclk_line,
      input dat_line
   );
endinterface
`default_nettype wire

//--- pkg/usi_pkg.sv
// Shared constants of the universal serial shift unit and its link partner
package usi_pkg;
   // ****************************************************
   // Widths and register offsets
   // ****************************************************
   localparam int DATA_W = 8;
   localparam int CNT_W = 4;
   localparam logic [1:0] ADDR_DATA = 2'h0;
   localparam logic [1:0] ADDR_STATUS = 2'h1;
   localparam logic [1:0] ADDR_CTRL = 2'h2;
   localparam logic [1:0] ADDR_PORT = 2'h3;
   localparam logic [3:0] CNT_MAX = 4'hF;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   // ****************************************************
   // Control register fields
   // ****************************************************
   localparam int CTRL_WAKE_START = 7;
   localparam int CTRL_WAKE_OVF = 6;
   localparam int CTRL_WM_HI = 5;
   localparam int CTRL_WM_LO = 4;
   localparam int CTRL_EXT = 3;
   localparam int CTRL_EDGE = 2;
   localparam int CTRL_SHIFT = 1;
   localparam int CTRL_TOGGLE = 0;
   // ****************************************************
   // Status register fields
   // ****************************************************
   localparam int STAT_START = 7;
   localparam int STAT_OVF = 6;
   localparam int STAT_STOP = 5;
   // ****************************************************
   // Port register fields
   // ****************************************************
   localparam int PORT_CLK = 0;
   localparam int PORT_DAT = 1;
   localparam int PORT_CLK_OE = 2;
   localparam int PORT_DAT_OE = 3;
   localparam logic [3:0] PORT_RESET = 4'h3;
   // ****************************************************
   // Wire modes and partner operations
   // ****************************************************
   localparam logic [1:0] WM_OFF = 2'h0;
   localparam logic [1:0] WM_THREE = 2'h1;
   localparam logic [1:0] WM_TWO = 2'h2;
   localparam logic [1:0] OP_BYTE = 2'h0;
   localparam logic [1:0] OP_START = 2'h1;
   localparam logic [1:0] OP_STOP = 2'h2;
   // ****************************************************
   // Timing
   // ****************************************************
   localparam int MCLK_PERIOD_PS = 5000;
   localparam int SCLK_HALF_NS = 80;
   localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * 1000) / MCLK_PERIOD_PS;
   localparam int SCLK_MIN_HALF_CYC = 2;
endpackage
